/* rtl/adc_seq_pkg.sv */
package adc_seq_pkg;
	localparam int          RES_W        = 10;
	localparam int          WORD_W       = 16;
	localparam int          BYTE_W       = 8;
	localparam int          MODE_W       = 8;
	localparam int          SLOT_W       = 2;
	localparam int          CH_W         = 3;
	localparam int          WORD_SHIFT   = 6;
	localparam int          BYTE_LSB     = 2;
	localparam int          START_BIT    = 7;
	localparam int          ENABLE_BIT   = 0;
	localparam logic [1:0]  SLOT_FIRST   = 2'h0;
	localparam logic [1:0]  SLOT_LAST    = 2'h3;
	localparam logic [15:0] WORD_RST     = 16'h0000;
	localparam logic [7:0]  BYTE_RST     = 8'h00;
	localparam int          CLK_HZ       = 10_000_000;
	localparam int          STAB_NS      = 1000;
	localparam int          STAB_CYCLES  = (STAB_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int          CONV_CYCLES  = 20;

	typedef enum logic [1:0] {
		ST_STOP      = 2'b00,
		ST_STANDBY   = 2'b01,
		ST_TRIG_WAIT = 2'b11,
		ST_CONVERT   = 2'b10
	} seq_state_e;

	typedef enum logic {
		TRIG_SW        = 1'b0,
		TRIG_HW_NOWAIT = 1'b1
	} trig_mode_e;
endpackage : adc_seq_pkg

/* rtl/trig_edge.sv */
`timescale 1ns/1ps
module trig_edge (
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	input  wire logic clk_en_i,
	input  wire logic trig_i,
	output logic      pulse_o
);
	logic prev_r;
	logic prev_nxt;

	always_comb begin
		prev_nxt = clk_en_i ? trig_i : prev_r;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
		end
	end

	// one enabled clock cycle per rising edge of the trigger level
	assign pulse_o = trig_i & ~prev_r;
endmodule : trig_edge

/* rtl/conv_timer.sv */
`timescale 1ns/1ps
module conv_timer #(
	parameter int CYCLES = adc_seq_pkg::CONV_CYCLES
) (
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	input  wire logic clk_en_i,
	input  wire logic kick_i,
	input  wire logic run_i,
	output logic      done_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

	logic          busy_r;
	logic          busy_nxt;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;

	// done comes from registers only: the sequencer derives kick from it
	assign done_o = busy_r && (cnt_r == '0);

	always_comb begin
		busy_nxt = busy_r;
		cnt_nxt  = cnt_r;
		if (kick_i) begin
			busy_nxt = 1'b1;
			cnt_nxt  = LOAD;
		end else if (!run_i || done_o) begin
			busy_nxt = 1'b0;
		end else if (busy_r) begin
			cnt_nxt = cnt_r - CW'(1);
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_r <= 1'b0;
			cnt_r  <= '0;
		end else if (clk_en_i) begin
			busy_r <= busy_nxt;
			cnt_r  <= cnt_nxt;
		end
	end
endmodule : conv_timer

/* rtl/adc_trigger_sequencer.sv */
`timescale 1ns/1ps
module adc_trigger_sequencer #(
	parameter int CH_W        = adc_seq_pkg::CH_W,
	parameter int CONV_CYCLES = adc_seq_pkg::CONV_CYCLES
) (
	input  wire logic                              ref_clk_i,
	input  wire logic                              rstn_i,
	input  wire logic                              clk_en_i,
	input  wire logic                              mode_wr_i,
	input  wire logic [adc_seq_pkg::MODE_W-1:0]    mode_wdata_i,
	input  wire logic                              channel_select_wr_i,
	input  wire logic [CH_W-1:0]                   channel_select_i,
	input  wire logic                              trig_mode_i,
	input  wire logic                              scan_mode_i,
	input  wire logic                              one_shot_i,
	input  wire logic                              hw_trigger_i,
	input  wire logic [adc_seq_pkg::RES_W-1:0]     sample_data_i,
	output logic [adc_seq_pkg::MODE_W-1:0]         converter_mode_reg0_o,
	output logic                                   converter_powered_o,
	output logic                                   converting_o,
	output logic [CH_W-1:0]                        active_channel_o,
	output logic [adc_seq_pkg::WORD_W-1:0]         result_word_reg_o,
	output logic [adc_seq_pkg::BYTE_W-1:0]         result_byte_reg_o,
	output logic                                   conversion_end_irq_o
);
	adc_seq_pkg::seq_state_e state_r, state_nxt;
	logic                              converter_enable_r, converter_enable_nxt;
	logic                              conversion_start_r, conversion_start_nxt;
	logic [adc_seq_pkg::SLOT_W-1:0]    slot_r, slot_nxt;
	logic [CH_W-1:0]                   chan_r, chan_nxt;
	logic [adc_seq_pkg::WORD_W-1:0]    word_r, word_nxt;
	logic [adc_seq_pkg::BYTE_W-1:0]    byte_r, byte_nxt;
	logic                              irq_r, irq_nxt;
	logic                              kick;
	logic                              store;
	logic                              done;
	logic                              trig_pulse;
	logic                              hw_mode;
	logic                              start_wr1;
	logic                              start_wr0;
	logic                              trig_go;
	logic                              restart;
	logic                              in_conv;
	logic                              group_end;

	trig_edge u_trig_edge (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.clk_en_i  (clk_en_i),
		.trig_i    (hw_trigger_i),
		.pulse_o   (trig_pulse)
	);

	conv_timer #(
		.CYCLES (CONV_CYCLES)
	) u_conv_timer (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.clk_en_i  (clk_en_i),
		.kick_i    (kick),
		.run_i     (state_nxt == adc_seq_pkg::ST_CONVERT),
		.done_o    (done)
	);

	function automatic logic [CH_W-1:0] chan_of(input logic [CH_W-1:0]               base,
	                                            input logic                          scan,
	                                            input logic [adc_seq_pkg::SLOT_W-1:0] slot);
		chan_of = scan ? base + CH_W'(slot) : base;
	endfunction : chan_of

	assign hw_mode   = (trig_mode_i == adc_seq_pkg::TRIG_HW_NOWAIT);
	// a write of 1 only counts while the converter is already enabled
	assign start_wr1 = mode_wr_i && mode_wdata_i[adc_seq_pkg::START_BIT]
	                   && converter_enable_r;
	assign start_wr0 = mode_wr_i && !mode_wdata_i[adc_seq_pkg::START_BIT];
	assign trig_go   = trig_pulse && hw_mode && conversion_start_r;
	assign restart   = start_wr1 || channel_select_wr_i || trig_go;
	assign in_conv   = (state_r == adc_seq_pkg::ST_CONVERT);
	assign group_end = !scan_mode_i || (slot_r == adc_seq_pkg::SLOT_LAST);

	always_comb begin
		state_nxt            = state_r;
		converter_enable_nxt = converter_enable_r;
		conversion_start_nxt = conversion_start_r;
		slot_nxt             = slot_r;
		kick                 = 1'b0;
		store                = 1'b0;
		if (mode_wr_i) begin
			converter_enable_nxt = mode_wdata_i[adc_seq_pkg::ENABLE_BIT];
		end
		if (start_wr1) begin
			conversion_start_nxt = 1'b1;
		end else if (start_wr0) begin
			conversion_start_nxt = 1'b0;
		end
		unique case (state_r)
			adc_seq_pkg::ST_STOP: begin
				conversion_start_nxt = 1'b0;
				if (converter_enable_r) begin
					state_nxt = adc_seq_pkg::ST_STANDBY;
				end
			end
			adc_seq_pkg::ST_STANDBY: begin
				if (!converter_enable_r) begin
					state_nxt            = adc_seq_pkg::ST_STOP;
					conversion_start_nxt = 1'b0;
				end else if (start_wr1 && hw_mode) begin
					state_nxt = adc_seq_pkg::ST_TRIG_WAIT;
				end else if (start_wr1) begin
					state_nxt = adc_seq_pkg::ST_CONVERT;
					slot_nxt  = adc_seq_pkg::SLOT_FIRST;
					kick      = 1'b1;
				end
			end
			adc_seq_pkg::ST_TRIG_WAIT: begin
				if (!converter_enable_r) begin
					state_nxt            = adc_seq_pkg::ST_STOP;
					conversion_start_nxt = 1'b0;
				end else if (start_wr0) begin
					state_nxt = adc_seq_pkg::ST_STANDBY;
				end else if (trig_go) begin
					state_nxt = adc_seq_pkg::ST_CONVERT;
					slot_nxt  = adc_seq_pkg::SLOT_FIRST;
					kick      = 1'b1;
				end
			end
			adc_seq_pkg::ST_CONVERT: begin
				if (!converter_enable_r) begin
					state_nxt            = adc_seq_pkg::ST_STOP;
					conversion_start_nxt = 1'b0;
				end else if (start_wr0) begin
					// powered standby in every mode; no stop without a disable
					state_nxt = adc_seq_pkg::ST_STANDBY;
				end else if (restart) begin
					// partial conversion dropped, timer reloaded
					slot_nxt = adc_seq_pkg::SLOT_FIRST;
					kick     = 1'b1;
				end else if (done) begin
					store = 1'b1;
					if (!group_end) begin
						slot_nxt = slot_r + adc_seq_pkg::SLOT_W'(1);
						kick     = 1'b1;
					end else if (one_shot_i && hw_mode) begin
						state_nxt = adc_seq_pkg::ST_TRIG_WAIT;
					end else if (one_shot_i) begin
						state_nxt            = adc_seq_pkg::ST_STANDBY;
						conversion_start_nxt = 1'b0;
					end else begin
						slot_nxt = adc_seq_pkg::SLOT_FIRST;
						kick     = 1'b1;
					end
				end
			end
		endcase
	end

	always_comb begin
		chan_nxt = kick ? chan_of(channel_select_i, scan_mode_i, slot_nxt) : chan_r;
		word_nxt = word_r;
		byte_nxt = byte_r;
		irq_nxt  = store;
		if (store) begin
			word_nxt = adc_seq_pkg::WORD_W'({sample_data_i, adc_seq_pkg::WORD_SHIFT'(0)});
			byte_nxt = sample_data_i[adc_seq_pkg::RES_W-1:adc_seq_pkg::BYTE_LSB];
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_r            <= adc_seq_pkg::ST_STOP;
			converter_enable_r <= 1'b0;
			conversion_start_r <= 1'b0;
			slot_r             <= adc_seq_pkg::SLOT_FIRST;
			chan_r             <= '0;
			word_r             <= adc_seq_pkg::WORD_RST;
			byte_r             <= adc_seq_pkg::BYTE_RST;
			irq_r              <= 1'b0;
		end else if (clk_en_i) begin
			state_r            <= state_nxt;
			converter_enable_r <= converter_enable_nxt;
			conversion_start_r <= conversion_start_nxt;
			slot_r             <= slot_nxt;
			chan_r             <= chan_nxt;
			word_r             <= word_nxt;
			byte_r             <= byte_nxt;
			irq_r              <= irq_nxt;
		end
	end

	always_comb begin
		converter_mode_reg0_o                          = '0;
		converter_mode_reg0_o[adc_seq_pkg::START_BIT]  = conversion_start_r;
		converter_mode_reg0_o[adc_seq_pkg::ENABLE_BIT] = converter_enable_r;
	end

	assign converter_powered_o  = (state_r != adc_seq_pkg::ST_STOP);
	assign converting_o         = in_conv;
	assign active_channel_o     = chan_r;
	assign result_word_reg_o    = word_r;
	assign result_byte_reg_o    = byte_r;
	assign conversion_end_irq_o = irq_r;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	sequence s_clean_done;
		clk_en_i && in_conv && converter_enable_r && !start_wr0 && !restart && done;
	endsequence

	sequence s_group_end;
		s_clean_done ##0 group_end;
	endsequence

	a_enable_standby: assert property (
		clk_en_i && state_r == adc_seq_pkg::ST_STOP && converter_enable_r
		|=> state_r == adc_seq_pkg::ST_STANDBY && !converting_o)
		else $error("enable from stop did not reach standby");

	a_disabled_start_ignored: assert property (
		clk_en_i && !converter_enable_r && !conversion_start_r
		|=> !conversion_start_r && !converting_o)
		else $error("start taken while converter disabled");

	a_done_stores_result: assert property (
		s_clean_done |=> conversion_end_irq_o
		&& result_word_reg_o == {$past(sample_data_i), 6'h00}
		&& result_byte_reg_o == $past(sample_data_i[9:2]))
		else $error("conversion end did not store result");

	a_scan_slot_step: assert property (
		s_clean_done ##0 (scan_mode_i && slot_r != adc_seq_pkg::SLOT_LAST)
		|=> in_conv && slot_r == $past(slot_r) + 2'h1)
		else $error("scan slot did not advance");

	a_sw_oneshot_end: assert property (
		s_group_end ##0 (one_shot_i && !hw_mode)
		|=> state_r == adc_seq_pkg::ST_STANDBY && !conversion_start_r)
		else $error("software one-shot did not clear start");

	a_hw_oneshot_end: assert property (
		s_group_end ##0 (one_shot_i && hw_mode)
		|=> state_r == adc_seq_pkg::ST_TRIG_WAIT && conversion_start_r)
		else $error("hardware one-shot did not rearm");

	a_sequential_wrap: assert property (
		s_group_end ##0 !one_shot_i |=> in_conv && slot_r == adc_seq_pkg::SLOT_FIRST)
		else $error("sequential conversion did not continue");

	a_restart_first_slot: assert property (
		clk_en_i && in_conv && converter_enable_r && !start_wr0 && restart
		|=> in_conv && slot_r == adc_seq_pkg::SLOT_FIRST ##1 !conversion_end_irq_o)
		else $error("abort did not restart at first slot");

	a_clear_to_standby: assert property (
		clk_en_i && in_conv && converter_enable_r && start_wr0
		|=> state_r == adc_seq_pkg::ST_STANDBY && converter_powered_o)
		else $error("clearing start did not enter standby");

	a_disable_stop: assert property (
		clk_en_i && state_r == adc_seq_pkg::ST_STANDBY && !converter_enable_r
		|=> state_r == adc_seq_pkg::ST_STOP)
		else $error("disable in standby did not stop");

	a_sw_ignores_trigger: assert property (
		clk_en_i && state_r == adc_seq_pkg::ST_STANDBY && !hw_mode && !mode_wr_i
		&& converter_enable_r && trig_pulse |=> state_r == adc_seq_pkg::ST_STANDBY)
		else $error("hardware trigger started software mode");

	a_hw_arm_only: assert property (
		clk_en_i && state_r == adc_seq_pkg::ST_STANDBY && hw_mode && start_wr1
		|=> state_r == adc_seq_pkg::ST_TRIG_WAIT ##1 !conversion_end_irq_o)
		else $error("hardware start did not only arm");

	a_armed_trigger_go: assert property (
		clk_en_i && state_r == adc_seq_pkg::ST_TRIG_WAIT && converter_enable_r
		&& !start_wr0 && trig_go |=> in_conv && slot_r == adc_seq_pkg::SLOT_FIRST)
		else $error("armed trigger did not start conversion");

	a_trigger_needs_start: assert property (
		clk_en_i && !in_conv && !conversion_start_r && !start_wr1 && trig_pulse
		|=> !converting_o)
		else $error("trigger started with start clear");

	a_trigger_one_cycle: assert property (
		clk_en_i && trig_pulse |=> !trig_pulse)
		else $error("trigger pulse longer than one cycle");
endmodule : adc_trigger_sequencer

/* sim/analog_core_model.sv */
`timescale 1ns/1ps
module analog_core_model (
	input  wire logic       ref_clk_i,
	input  wire logic       rstn_i,
	input  wire logic [2:0] channel_i,
	input  wire logic       fire_i,
	output logic [9:0]      sample_data_o,
	output logic            hw_trigger_o
);
	// sample value names the channel so the bench can tell slots apart
	assign sample_data_o = {channel_i, 7'h2B};

	// trigger source is a level that rises one edge after the bench asks
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			hw_trigger_o <= 1'b0;
		end else begin
			hw_trigger_o <= fire_i;
		end
	end
endmodule : analog_core_model

/* sim/tb_adc_trigger_sequencer.sv */
`timescale 1ns/1ps
module tb_adc_trigger_sequencer;
	localparam int C = 8;
	logic        ref_clk_i;
	logic        rstn_i;
	logic        clk_en;
	logic        mode_wr;
	logic [7:0]  mode_wdata;
	logic        chan_wr;
	logic [2:0]  chan;
	logic        trig_mode;
	logic        scan_mode;
	logic        one_shot;
	logic        fire;
	logic        hw_trig;
	logic [9:0]  sample;
	logic [7:0]  mode_reg;
	logic        powered;
	logic        converting;
	logic [2:0]  act_ch;
	logic [15:0] word;
	logic [7:0]  byte_res;
	logic        irq;
	int          fails;
	int          num_checks;
	int          irq_cnt;
	int          n0;

	adc_trigger_sequencer #(.CH_W(3), .CONV_CYCLES(C)) i_dut (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(clk_en),
		.mode_wr_i(mode_wr), .mode_wdata_i(mode_wdata),
		.channel_select_wr_i(chan_wr), .channel_select_i(chan),
		.trig_mode_i(trig_mode), .scan_mode_i(scan_mode), .one_shot_i(one_shot),
		.hw_trigger_i(hw_trig), .sample_data_i(sample),
		.converter_mode_reg0_o(mode_reg), .converter_powered_o(powered),
		.converting_o(converting), .active_channel_o(act_ch),
		.result_word_reg_o(word), .result_byte_reg_o(byte_res),
		.conversion_end_irq_o(irq)
	);

	analog_core_model i_core (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .channel_i(act_ch),
		.fire_i(fire), .sample_data_o(sample), .hw_trigger_o(hw_trig)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		if (irq === 1'b1) irq_cnt++;
	end

	task automatic stop_test();
		$display("checks=%0d fails=%0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_flag(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_flag

	task automatic wr_mode(input logic [7:0] v);
		@(posedge ref_clk_i);
		mode_wr <= 1'b1;
		mode_wdata <= v;
		@(posedge ref_clk_i);
		mode_wr <= 1'b0;
	endtask : wr_mode

	task automatic wr_chan(input logic [2:0] v);
		@(posedge ref_clk_i);
		chan_wr <= 1'b1;
		chan <= v;
		@(posedge ref_clk_i);
		chan_wr <= 1'b0;
	endtask : wr_chan

	task automatic pulse_trig();
		@(posedge ref_clk_i);
		fire <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		fire <= 1'b0;
	endtask : pulse_trig

	task automatic idle(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : idle

	// waits for one stored result and checks both result registers
	task automatic expect_conv(input logic [2:0] ch, output int n);
		logic [9:0] d;
		d = {ch, 7'h2B};
		n = 0;
		// always steps past the cycle that showed the previous result
		do begin
			@(posedge ref_clk_i);
			#1;
			n++;
		end while (n < 100 && irq !== 1'b1);
		chk_flag(irq, 1'b1);
		chk_word(word, {d, 6'h00});
		chk_word({8'h00, byte_res}, {8'h00, d[9:2]});
	endtask : expect_conv

	task automatic expect_scan(input logic [2:0] base, input int k);
		int n;
		for (int i = 0; i < k; i++) begin
			expect_conv(base + 3'(i % 4), n);
		end
	endtask : expect_scan

	initial begin
		int n;
		rstn_i = 1'b0; mode_wr = 1'b0; mode_wdata = 8'h00; chan_wr = 1'b0; chan = 3'h0;
		trig_mode = 1'b0; scan_mode = 1'b1; one_shot = 1'b1; fire = 1'b0;
		fails = 0; num_checks = 0; irq_cnt = 0;
		clk_en = 1'b1;
		repeat (8) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		#1;
		chk_word(word, 16'h0000);
		chk_word({8'h00, byte_res}, 16'h0000);
		wr_chan(3'h2);
		wr_mode(8'h80);
		idle(3);
		chk_word({8'h00, mode_reg}, 16'h0000);
		chk_flag(converting, 1'b0);
		wr_mode(8'h01);
		idle(2);
		chk_flag(powered, 1'b1);
		chk_flag(converting, 1'b0);
		idle(adc_seq_pkg::STAB_CYCLES);
		pulse_trig();
		idle(4);
		chk_flag(converting, 1'b0);
		wr_mode(8'h81);
		expect_conv(3'h2, n);
		chk_word(16'(n), 16'(C));
		expect_scan(3'h3, 3);
		chk_word({8'h00, mode_reg}, 16'h0001);
		idle(1);
		chk_flag(converting, 1'b0);
		wr_mode(8'h81);
		expect_conv(3'h2, n);
		wr_mode(8'h81);
		expect_conv(3'h2, n);
		wr_chan(3'h5);
		expect_scan(3'h5, 4);
		wr_mode(8'h81);
		idle(2);
		wr_mode(8'h01);
		n0 = irq_cnt;
		idle(2 * C + 2);
		chk_flag(converting, 1'b0);
		chk_flag(powered, 1'b1);
		chk_word(16'(irq_cnt), 16'(n0));
		wr_mode(8'h00);
		idle(2);
		chk_flag(powered, 1'b0);
		trig_mode <= 1'b1;
		scan_mode <= 1'b0;
		wr_chan(3'h3);
		wr_mode(8'h01);
		idle(adc_seq_pkg::STAB_CYCLES + 2);
		wr_mode(8'h81);
		idle(2 * C);
		chk_flag(converting, 1'b0);
		pulse_trig();
		expect_conv(3'h3, n);
		chk_word({8'h00, mode_reg}, 16'h0081);
		idle(2);
		chk_flag(converting, 1'b0);
		pulse_trig();
		// four frozen edges: result lands C edges after the thaw, not C-4
		clk_en <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		clk_en <= 1'b1;
		expect_conv(3'h3, n);
		chk_word(16'(n), 16'(C));
		wr_mode(8'h01);
		idle(2);
		n0 = irq_cnt;
		pulse_trig();
		idle(2 * C + 4);
		chk_flag(converting, 1'b0);
		chk_word(16'(irq_cnt), 16'(n0));
		one_shot <= 1'b0;
		wr_mode(8'h81);
		pulse_trig();
		expect_conv(3'h3, n);
		idle(1);
		expect_conv(3'h3, n);
		idle(1);
		expect_conv(3'h3, n);
		wr_mode(8'h01);
		scan_mode <= 1'b1;
		wr_mode(8'h81);
		pulse_trig();
		expect_conv(3'h3, n);
		pulse_trig();
		expect_conv(3'h3, n);
		expect_scan(3'h4, 3);
		expect_scan(3'h3, 2);
		wr_mode(8'h01);
		idle(2 * C);
		chk_flag(converting, 1'b0);
		chk_flag(powered, 1'b1);
		stop_test();
	end

	initial begin
		#(20000 * 100);
		fails++;
		stop_test();
	end
endmodule : tb_adc_trigger_sequencer
